// ==== rtl/asrtc_pkg.sv ====
// shared constants and types for the async serial rx/tx block
package asrtc_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] ADDR_STAT1 = 8'h00;
  localparam logic [7:0] ADDR_STAT2 = 8'h04;
  localparam logic [7:0] ADDR_CTRL3 = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0C;
  localparam logic [7:0] ADDR_BAUD = 8'h10;
  localparam logic [7:0] ADDR_CTRL2 = 8'h14;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ****************************************
  // reset values and widths
  // ****************************************
  localparam int DIV_W = 13;
  localparam logic [12:0] BAUD_RST = 13'h0000;
  localparam logic [7:0] STAT1_RST = 8'hC0;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] CTRL3_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ****************************************
  // sampling and frame counts
  // ****************************************
  // oversample index n stands for sample RT(n+1)
  localparam logic [3:0] RT3 = 4'h2;
  localparam logic [3:0] RT5 = 4'h4;
  localparam logic [3:0] RT7 = 4'h6;
  localparam logic [3:0] RT8 = 4'h7;
  localparam logic [3:0] RT9 = 4'h8;
  localparam logic [3:0] RT10 = 4'h9;
  localparam logic [3:0] RT16 = 4'hF;
  localparam logic [3:0] DATA_BITS8 = 4'h8;
  localparam logic [3:0] DATA_BITS9 = 4'h9;
  localparam logic [3:0] FRAME_BITS8 = 4'hA;
  localparam logic [3:0] FRAME_BITS9 = 4'hB;
  localparam logic [7:0] IDLE_TICKS8 = 8'hA0;
  localparam logic [7:0] IDLE_TICKS9 = 8'hB0;

  // ****************************************
  // register layouts
  // ****************************************
  typedef struct packed {
    logic tdre;
    logic tc;
    logic rx_buffer_full_flag;
    logic idle;
    logic overrun;
    logic noise;
    logic framing;
    logic parity;
  } asrtc_stat1_t;

  typedef struct packed {
    logic rx_ninth_bit;
    logic tx_ninth_bit;
    logic single_wire_pin_direction;
    logic rsvd;
    logic overrun_irq_enable;
    logic noise_irq_enable;
    logic framing_irq_enable;
    logic parity_irq_enable;
  } asrtc_ctrl3_t;

  typedef struct packed {
    logic char_len;
    logic loop_select;
    logic receiver_source_select;
    logic parity_enable;
    logic parity_odd;
    logic tx_enable;
    logic rx_enable;
    logic rsvd;
  } asrtc_ctrl2_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } asrtc_rx_state_t;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SHIFT = 1'b1
  } asrtc_tx_state_t;

endpackage : asrtc_pkg

// ==== rtl/asrtc_baud_gen.sv ====
// baud divider producing the 16x oversampling tick
`timescale 1ns/1ns
module asrtc_baud_gen
  import asrtc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick
);

  logic [DIV_W-1:0] cnt_ff;
  logic [DIV_W-1:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  // zero divisor holds the generator stopped
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (divisor == '0) begin
      nxt_cnt = '0;
    end else if (cnt_ff >= divisor - 13'h0001) begin
      nxt_cnt = '0;
      nxt_tick = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + 13'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule : asrtc_baud_gen

// ==== rtl/asrtc_top.sv ====
// async serial rx/tx with axi4-lite register slave
// Behaviour
// - receiver active set on start, cleared idle
// - status two read-only, writes ignored
// - ninth received bit shown in control three
// - nine-bit value moved to shifter together
// - tx ninth bit kept between characters
// - single-wire direction bit drives pin enable
// - overrun flag and enable raise request
// - noise flag and enable raise request
// - framing flag and enable raise request
// - parity flag and enable raise request
// - data reads rx buffer, writes tx buffer
// - data access completes flag clearing
// - independent rx and tx, shared baud
// - baud generator runs from bus clock
// - receiver realigns on falling edges during data and stop bits
// - length bit picks eight or nine bits
// - start low, data lsb first, stop high
// - overrun clears by status then data read
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
module asrtc_top
  import asrtc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd_i,
  input wire logic txd_i,
  output logic txd_o,
  output logic txd_oe,
  output logic err_irq
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] pin_raw;
  logic [1:0] sync1_ff;
  logic [1:0] sync2_ff;
  assign pin_raw = {txd_i, rxd_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sync1_ff[gi] <= 1'b1;
          sync2_ff[gi] <= 1'b1;
        end else begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // declarations
  // ****************************************
  asrtc_ctrl2_t ctrl2_ff, nxt_ctrl2;
  asrtc_ctrl3_t ctrl3_ff, nxt_ctrl3;
  asrtc_stat1_t stat_ff, nxt_stat, clr_mask_ff, nxt_clr_mask;
  logic [DIV_W-1:0] baud_ff, nxt_baud;
  logic [7:0] tx_buf_ff, nxt_tx_buf;
  logic [7:0] rx_buf_ff, nxt_rx_buf;
  logic raf_ff, nxt_raf;
  logic idle_arm_ff, nxt_idle_arm;
  logic aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
  logic [7:0] awaddr_ff, nxt_awaddr, wdata_ff, nxt_wdata;
  logic wstrb0_ff, nxt_wstrb0;
  logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [7:0] rdata_ff, nxt_rdata;
  logic do_wr, do_rd, wr_ok, rd_stat1, rd_data, wr_data;
  logic tick;
  // receiver
  asrtc_rx_state_t rx_st_ff, nxt_rx_st;
  logic [3:0] rx_rt_ff, nxt_rx_rt, rx_bit_ff, nxt_rx_bit;
  logic [2:0] hist_ff, nxt_hist, vote_ff, nxt_vote;
  logic [8:0] rx_sh_ff, nxt_rx_sh;
  logic rx_noise_ff, nxt_rx_noise;
  logic [7:0] idle_cnt_ff, nxt_idle_cnt;
  logic rx_s, edge_fall, bit_end, maj, frame_done, stop_bit, par_bad;
  logic [7:0] got_data;
  // transmitter
  asrtc_tx_state_t tx_st_ff, nxt_tx_st;
  logic [10:0] tx_sh_ff, nxt_tx_sh;
  logic [3:0] tx_rt_ff, nxt_tx_rt, tx_bit_ff, nxt_tx_bit;
  logic tx_line_ff, nxt_tx_line, tx_load;

  // ****************************************
  // baud generator
  // ****************************************
  asrtc_baud_gen u_baud (
    .clk(clk),
    .rst(rst),
    .divisor(baud_ff),
    .tick(tick)
  );

  // ****************************************
  // axi4-lite slave
  // ****************************************
  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready = !w_held_ff;
  assign s_axi_arready = !rvalid_ff;
  assign do_wr = aw_held_ff && w_held_ff && !bvalid_ff;
  assign do_rd = s_axi_arvalid && !rvalid_ff;
  assign wr_ok = do_wr && wstrb0_ff;
  assign rd_stat1 = do_rd && (s_axi_araddr == ADDR_STAT1);
  assign rd_data = do_rd && (s_axi_araddr == ADDR_DATA);
  assign wr_data = wr_ok && (awaddr_ff == ADDR_DATA);

  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_awaddr = awaddr_ff;
    nxt_w_held = w_held_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb0 = wstrb0_ff;
    nxt_bvalid = bvalid_ff && !s_axi_bready;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff && !s_axi_rready;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (s_axi_awvalid && !aw_held_ff) begin
      nxt_aw_held = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_ff) begin
      nxt_w_held = 1'b1;
      nxt_wdata = s_axi_wdata[7:0];
      nxt_wstrb0 = s_axi_wstrb[0];
    end
    if (do_wr) begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      if (awaddr_ff == ADDR_STAT1 || awaddr_ff == ADDR_STAT2 ||
          awaddr_ff == ADDR_CTRL3 || awaddr_ff == ADDR_DATA ||
          awaddr_ff == ADDR_BAUD || awaddr_ff == ADDR_CTRL2) begin
        nxt_bresp = RESP_OKAY;
      end else begin
        nxt_bresp = RESP_SLVERR;
      end
    end
    if (do_rd) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      if (s_axi_araddr == ADDR_STAT1) begin
        nxt_rdata = stat_ff;
      end else if (s_axi_araddr == ADDR_STAT2) begin
        nxt_rdata = {7'h00, raf_ff};
      end else if (s_axi_araddr == ADDR_CTRL3) begin
        nxt_rdata = {ctrl3_ff[7:5], 1'b0, ctrl3_ff[3:0]};
      end else if (s_axi_araddr == ADDR_DATA) begin
        nxt_rdata = rx_buf_ff;
      end else if (s_axi_araddr == ADDR_BAUD) begin
        nxt_rdata = baud_ff[7:0];
      end else if (s_axi_araddr == ADDR_CTRL2) begin
        nxt_rdata = {ctrl2_ff[7:1], 1'b0};
      end else begin
        nxt_rdata = 8'h00;
        nxt_rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      w_held_ff <= 1'b0;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 8'h00;
    end else begin
      aw_held_ff <= nxt_aw_held;
      awaddr_ff <= nxt_awaddr;
      w_held_ff <= nxt_w_held;
      wdata_ff <= nxt_wdata;
      wstrb0_ff <= nxt_wstrb0;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = {24'h00_0000, rdata_ff};

  // ****************************************
  // receiver
  // ****************************************
  // single-wire reads the pin, plain loop reads own tx
  assign rx_s = ctrl2_ff.loop_select ?
                (ctrl2_ff.receiver_source_select ? sync2_ff[1] : tx_line_ff)
                : sync2_ff[0];
  assign edge_fall = hist_ff[0] && !rx_s;
  // late edge starts the next bit, early edge re-times this one
  assign bit_end = (rx_rt_ff == RT16) || (edge_fall && rx_rt_ff > RT10);
  // majority of the rt8, rt9 and rt10 samples
  assign maj = (vote_ff[0] & vote_ff[1]) | (vote_ff[1] & rx_s) |
               (vote_ff[0] & rx_s);
  assign frame_done = tick && rx_st_ff == RX_STOP && rx_rt_ff == RT10;
  assign stop_bit = maj;
  assign got_data = ctrl2_ff.char_len ? rx_sh_ff[7:0] : rx_sh_ff[8:1];
  assign par_bad = ctrl2_ff.parity_enable &&
                   ((ctrl2_ff.char_len ? ^rx_sh_ff : ^rx_sh_ff[8:1]) !=
                    ctrl2_ff.parity_odd);

  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_rt = rx_rt_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_hist = hist_ff;
    nxt_vote = vote_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_noise = rx_noise_ff;
    nxt_idle_cnt = idle_cnt_ff;
    if (!ctrl2_ff.rx_enable) begin
      nxt_rx_st = RX_IDLE;
      nxt_hist = 3'b000;
      nxt_idle_cnt = 8'h00;
    end else if (tick) begin
      nxt_hist = {hist_ff[1:0], rx_s};
      nxt_rx_rt = rx_rt_ff + 4'h1;
      if (rx_rt_ff == RT3 || rx_rt_ff == RT5 || rx_rt_ff == RT7 ||
          rx_rt_ff == RT8 || rx_rt_ff == RT9 || rx_rt_ff == RT10) begin
        nxt_vote = {vote_ff[1:0], rx_s};
      end
      case (rx_st_ff)
        RX_IDLE: begin
          nxt_idle_cnt = rx_s ? idle_cnt_ff + 8'h01 : 8'h00;
          if (hist_ff == 3'b111 && !rx_s) begin
            nxt_rx_st = RX_START;
            nxt_rx_rt = 4'h1;
            nxt_rx_noise = 1'b0;
            nxt_idle_cnt = 8'h00;
          end
        end
        RX_START: begin
          // start valid when two of RT3/5/7 are low
          if (rx_rt_ff == RT7 && (vote_ff[1:0] == 2'b11 ||
              (vote_ff[1:0] != 2'b00 && rx_s))) begin
            nxt_rx_st = RX_IDLE;
          end
          if (rx_rt_ff >= RT8 && rx_rt_ff <= RT10 && rx_s) begin
            nxt_rx_noise = 1'b1;
          end
          if (rx_rt_ff == RT16) begin
            nxt_rx_st = RX_DATA;
            nxt_rx_bit = 4'h0;
          end
        end
        RX_DATA: begin
          if (rx_rt_ff == RT10) begin
            // lsb first: shift in at the top
            nxt_rx_sh = {stop_bit, rx_sh_ff[8:1]};
            if (vote_ff[1] != vote_ff[0] || vote_ff[0] != rx_s) begin
              nxt_rx_noise = 1'b1;
            end
          end
          if (bit_end) begin
            nxt_rx_bit = rx_bit_ff + 4'h1;
            if (rx_bit_ff + 4'h1 == (ctrl2_ff.char_len ?
                DATA_BITS9 : DATA_BITS8)) begin
              nxt_rx_st = RX_STOP;
            end
          end
          if (edge_fall) begin
            nxt_rx_rt = 4'h1;
          end
        end
        RX_STOP: begin
          if (edge_fall) begin
            nxt_rx_rt = 4'h1;
          end
          if (rx_rt_ff == RT10) begin
            nxt_rx_st = RX_IDLE;
            if (vote_ff[1] != vote_ff[0] || vote_ff[0] != rx_s) begin
              nxt_rx_noise = 1'b1;
            end
            // refill edge history unless a break came in
            nxt_hist = (!stop_bit && got_data == 8'h00) ? 3'b000 : 3'b111;
          end
        end
        default: nxt_rx_st = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_st_ff <= RX_IDLE;
      rx_rt_ff <= 4'h0;
      rx_bit_ff <= 4'h0;
      hist_ff <= 3'b000;
      vote_ff <= 3'b000;
      rx_sh_ff <= 9'h000;
      rx_noise_ff <= 1'b0;
      idle_cnt_ff <= 8'h00;
    end else begin
      rx_st_ff <= nxt_rx_st;
      rx_rt_ff <= nxt_rx_rt;
      rx_bit_ff <= nxt_rx_bit;
      hist_ff <= nxt_hist;
      vote_ff <= nxt_vote;
      rx_sh_ff <= nxt_rx_sh;
      rx_noise_ff <= nxt_rx_noise;
      idle_cnt_ff <= nxt_idle_cnt;
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  assign tx_load = tick && tx_st_ff == TX_IDLE && ctrl2_ff.tx_enable &&
                   !stat_ff.tdre;

  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_rt = tx_rt_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_line = tx_line_ff;
    case (tx_st_ff)
      TX_IDLE: begin
        nxt_tx_line = 1'b1;
        if (tx_load) begin
          // stop, ninth bit, byte, start go in as one word
          nxt_tx_sh = {1'b1, ctrl2_ff.char_len ? ctrl3_ff.tx_ninth_bit
                       : 1'b1, tx_buf_ff, 1'b0};
          nxt_tx_bit = ctrl2_ff.char_len ? FRAME_BITS9 : FRAME_BITS8;
          nxt_tx_rt = 4'h0;
          nxt_tx_line = 1'b0;
          nxt_tx_st = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (tick) begin
          nxt_tx_rt = tx_rt_ff + 4'h1;
          if (tx_rt_ff == RT16) begin
            nxt_tx_sh = {1'b1, tx_sh_ff[10:1]};
            nxt_tx_bit = tx_bit_ff - 4'h1;
            nxt_tx_line = tx_sh_ff[1];
            if (tx_bit_ff == 4'h1) begin
              nxt_tx_st = TX_IDLE;
              nxt_tx_line = 1'b1;
            end
          end
        end
      end
      default: nxt_tx_st = TX_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_ff <= TX_IDLE;
      tx_sh_ff <= 11'h7FF;
      tx_rt_ff <= 4'h0;
      tx_bit_ff <= 4'h0;
      tx_line_ff <= 1'b1;
    end else begin
      tx_st_ff <= nxt_tx_st;
      tx_sh_ff <= nxt_tx_sh;
      tx_rt_ff <= nxt_tx_rt;
      tx_bit_ff <= nxt_tx_bit;
      tx_line_ff <= nxt_tx_line;
    end
  end

  assign txd_o = tx_line_ff;
  assign txd_oe = (ctrl2_ff.loop_select && ctrl2_ff.receiver_source_select)
                  ? ctrl3_ff.single_wire_pin_direction
                  : ctrl2_ff.tx_enable;

  // ****************************************
  // registers and status flags
  // ****************************************
  always_comb begin
    nxt_ctrl2 = ctrl2_ff;
    nxt_ctrl3 = ctrl3_ff;
    nxt_baud = baud_ff;
    nxt_tx_buf = tx_buf_ff;
    nxt_rx_buf = rx_buf_ff;
    nxt_stat = stat_ff;
    nxt_clr_mask = clr_mask_ff;
    nxt_raf = raf_ff;
    nxt_idle_arm = idle_arm_ff;
    if (wr_ok && awaddr_ff == ADDR_CTRL2) begin
      nxt_ctrl2 = {wdata_ff[7:1], 1'b0};
    end
    if (wr_ok && awaddr_ff == ADDR_CTRL3) begin
      // rx ninth bit is hardware-owned; tx ninth bit held until rewritten
      nxt_ctrl3[6:0] = {wdata_ff[6:5], 1'b0, wdata_ff[3:0]};
    end
    if (wr_ok && awaddr_ff == ADDR_BAUD) begin
      nxt_baud = {5'h00, wdata_ff};
    end
    // status two has no write path
    // first half of clearing: remember what was seen set
    if (rd_stat1) begin
      nxt_clr_mask = stat_ff;
    end
    // second half: data read clears what was seen
    if (rd_data) begin
      nxt_stat[5:0] = stat_ff[5:0] & ~clr_mask_ff[5:0];
      nxt_clr_mask[5:0] = 6'h00;
    end
    if (wr_data) begin
      nxt_tx_buf = wdata_ff;
      nxt_stat.tdre = 1'b0;
      nxt_stat.tc = 1'b0;
      nxt_clr_mask.tdre = 1'b0;
      nxt_clr_mask.tc = 1'b0;
    end
    if (tx_load) begin
      nxt_stat.tdre = 1'b1;
    end
    if (tx_st_ff == TX_SHIFT && nxt_tx_st == TX_IDLE && stat_ff.tdre &&
        !wr_data) begin
      nxt_stat.tc = 1'b1;
    end
    // set wins over a clear in the same cycle
    if (frame_done && !nxt_stat.framing) begin
      if (nxt_stat.rx_buffer_full_flag) begin
        nxt_stat.overrun = 1'b1;
      end else begin
        nxt_rx_buf = got_data;
        nxt_ctrl3.rx_ninth_bit = rx_sh_ff[8];
        nxt_stat.rx_buffer_full_flag = 1'b1;
        nxt_stat.noise = rx_noise_ff || (vote_ff[1] != vote_ff[0]) ||
                         (vote_ff[0] != rx_s);
        nxt_stat.framing = !stop_bit;
        nxt_stat.parity = par_bad;
        nxt_idle_arm = 1'b1;
      end
    end
    if (tick && rx_st_ff == RX_START && rx_rt_ff == RT7 &&
        nxt_rx_st == RX_START) begin
      nxt_raf = 1'b1;
    end
    if (rx_st_ff == RX_IDLE && idle_cnt_ff ==
        (ctrl2_ff.char_len ? IDLE_TICKS9 : IDLE_TICKS8)) begin
      nxt_raf = 1'b0;
      if (idle_arm_ff) begin
        nxt_stat.idle = 1'b1;
        nxt_idle_arm = 1'b0;
      end
    end
    if (!ctrl2_ff.rx_enable) begin
      nxt_raf = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl2_ff <= CTRL2_RST;
      ctrl3_ff <= CTRL3_RST;
      baud_ff <= BAUD_RST;
      tx_buf_ff <= DATA_RST;
      rx_buf_ff <= DATA_RST;
      stat_ff <= STAT1_RST;
      clr_mask_ff <= 8'h00;
      raf_ff <= 1'b0;
      idle_arm_ff <= 1'b0;
    end else begin
      ctrl2_ff <= nxt_ctrl2;
      ctrl3_ff <= nxt_ctrl3;
      baud_ff <= nxt_baud;
      tx_buf_ff <= nxt_tx_buf;
      rx_buf_ff <= nxt_rx_buf;
      stat_ff <= nxt_stat;
      clr_mask_ff <= nxt_clr_mask;
      raf_ff <= nxt_raf;
      idle_arm_ff <= nxt_idle_arm;
    end
  end

  // ****************************************
  // error request
  // ****************************************
  assign err_irq =
    (stat_ff.overrun && ctrl3_ff.overrun_irq_enable) ||
    (stat_ff.noise && ctrl3_ff.noise_irq_enable) ||
    (stat_ff.framing && ctrl3_ff.framing_irq_enable) ||
    (stat_ff.parity && ctrl3_ff.parity_irq_enable);

endmodule : asrtc_top

// ==== dv/asrtc_monitor.sv ====
// port checker for the serial block
`timescale 1ns/1ns
module asrtc_monitor
  import asrtc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic txd_o,
  input wire logic err_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire ar_go = s_axi_arvalid && s_axi_arready;
  chk_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write not answered");
  chk_rd_answer: assert property (
    ar_go |=> s_axi_rvalid) else $error("read not answered");
  chk_bad_addr: assert property (
    ar_go && s_axi_araddr > ADDR_CTRL2 |=> s_axi_rresp == RESP_SLVERR
    && s_axi_rdata == '0) else $error("unmapped read accepted");
  chk_stat2_bits: assert property (
    ar_go && s_axi_araddr == ADDR_STAT2 |=> s_axi_rdata[31:1] == '0)
    else $error("status two has extra bits");
  chk_data_width: assert property (
    ar_go && s_axi_araddr == ADDR_DATA |=> s_axi_rdata[31:8] == '0)
    else $error("data read too wide");
  chk_irq_clear: assert property (
    $fell(err_irq) |-> s_axi_rvalid || $past(s_axi_rvalid) || s_axi_bvalid)
    else $error("error request dropped without access");
  chk_reset_quiet: assert property (disable iff (1'b0)
    rst |-> txd_o && !err_irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active in reset");
  chk_start_len: assert property (
    $fell(txd_o) |-> !txd_o [*8]) else $error("start bit too short");
  cover property (ar_go && s_axi_araddr == ADDR_STAT2);
  cover property ($rose(err_irq));
  cover property ($fell(txd_o));
endmodule : asrtc_monitor
bind asrtc_top asrtc_monitor u_mon (.*);

// ==== dv/asrtc_remote.sv ====
// remote serial device: frame sender and line capture
`timescale 1ns/1ns
module asrtc_remote #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk,
  input wire logic line,
  output logic rxd
);
  logic [9:0] got;
  int n_got = 0;
  initial rxd = 1'b1;
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rxd <= 1'b1;
    @(posedge clk);
  endtask : send
  // mid-bit samples of nine data bits and stop
  always begin
    @(negedge line);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      got[i] = line;
    end
    n_got++;
  end
endmodule : asrtc_remote

// ==== dv/async_serial_rx_tx_control_test.sv ====
// self-checking bench for the serial block
`timescale 1ns/1ns
module async_serial_rx_tx_control_test;
  import asrtc_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [15:0] w;
    logic [7:0] e;
    logic [1:0] r;
  } asrtc_row_t;
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, txd_o, txd_oe, err_irq, rxd_i;
  wire logic txd_i = txd_oe ? txd_o : 1'b1;
  int num_errors = 0, check_count = 0;
  asrtc_row_t rows [7] = '{
    '{ADDR_STAT2, 16'h00FF, 8'h00, RESP_OKAY},
    '{ADDR_STAT1, 16'h00FF, 8'hC0, RESP_OKAY},
    '{ADDR_CTRL3, 16'h00FF, 8'h6F, RESP_OKAY},
    '{ADDR_CTRL3, 16'h0000, 8'h00, RESP_OKAY},
    '{ADDR_BAUD, 16'h1FFF, 8'hFF, RESP_OKAY},
    '{ADDR_CTRL2, 16'h0000, 8'h00, RESP_OKAY},
    '{8'h18, 16'h00FF, 8'h00, RESP_SLVERR}};
  asrtc_top u_dut (.*);
  asrtc_remote u_rem (.clk(clk), .line(txd_i), .rxd(rxd_i));
  always #20 clk = ~clk;
  // ****************
  // bus and check tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(negedge clk); while (!(s_axi_awready && s_axi_wready));
    @(posedge clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(negedge clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge clk); while (!s_axi_arready);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk);
  endtask : rd
  task automatic wait_got(input int k);
    for (int i = 0; i < 3000 && u_rem.n_got < k; i++) @(negedge clk);
    @(posedge clk);
  endtask : wait_got
  task automatic give_verdict();
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    #(40 * 30000);
    num_errors++;
    give_verdict();
  end
  initial begin
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADDR_DATA);
    chk(d, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(rows[i].a, 32'(rows[i].w));
      chk(32'(r), 32'(rows[i].r));
      rd(rows[i].a);
      chk(d, 32'(rows[i].e));
      chk(32'(r), 32'(rows[i].r));
    end
    wr(ADDR_BAUD, 32'h0000_0001);
    wr(ADDR_CTRL2, 32'h0000_0084);
    wr(ADDR_CTRL3, 32'h0000_0040);
    wr(ADDR_DATA, 32'h0000_00A5);
    wr(ADDR_DATA, 32'h0000_003C);
    chk(32'(txd_oe), 32'h0000_0001);
    wait_got(1);
    chk(32'(u_rem.got), 32'h0000_03A5);
    wait_got(2);
    chk(32'(u_rem.got), 32'h0000_033C);
    wr(ADDR_CTRL2, 32'h0000_0086);
    fork
      u_rem.send(11'h6B4, 11);
      begin
        repeat (60) @(posedge clk);
        rd(ADDR_STAT2);
        chk(d, 32'h0000_0001);
      end
    join
    repeat (400) @(posedge clk);
    rd(ADDR_CTRL3);
    chk(d, 32'h0000_00C0);
    rd(ADDR_STAT1);
    chk(32'(d[5]), 32'h0000_0001);
    rd(ADDR_DATA);
    chk(d, 32'h0000_005A);
    rd(ADDR_STAT2);
    chk(d, 32'h0000_0000);
    wr(ADDR_CTRL3, 32'h0000_0008);
    u_rem.send(11'h6B4, 11);
    u_rem.send(11'h6B4, 11);
    repeat (40) @(posedge clk);
    chk(32'(err_irq), 32'h0000_0001);
    rd(ADDR_DATA);
    chk(32'(err_irq), 32'h0000_0001);
    wr(ADDR_CTRL3, 32'h0000_0000);
    chk(32'(err_irq), 32'h0000_0000);
    wr(ADDR_CTRL3, 32'h0000_0008);
    rd(ADDR_STAT1);
    rd(ADDR_DATA);
    chk(32'(err_irq), 32'h0000_0000);
    wr(ADDR_CTRL3, 32'h0000_0002);
    u_rem.send(11'h2B4, 11);
    repeat (40) @(posedge clk);
    chk(32'(err_irq), 32'h0000_0001);
    rd(ADDR_STAT1);
    rd(ADDR_DATA);
    chk(32'(err_irq), 32'h0000_0000);
    repeat (400) @(posedge clk);
    rd(ADDR_STAT1);
    rd(ADDR_DATA);
    wr(ADDR_CTRL2, 32'h0000_0096);
    wr(ADDR_CTRL3, 32'h0000_0004);
    u_rem.send(11'h6B4, 11);
    repeat (40) @(posedge clk);
    chk(32'(err_irq), 32'h0000_0000);
    wr(ADDR_CTRL3, 32'h0000_0001);
    chk(32'(err_irq), 32'h0000_0001);
    rd(ADDR_STAT1);
    chk(d, 32'h0000_00E1);
    wr(ADDR_CTRL2, 32'h0000_0060);
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CTRL3, 32'(i) << 5);
      chk(32'(txd_oe), 32'(i));
    end
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'(txd_oe), 32'h0000_0000);
    rd(ADDR_STAT1);
    chk(d, 32'h0000_00C0);
    rd(ADDR_CTRL3);
    chk(d, 32'h0000_0000);
    give_verdict();
  end
endmodule : async_serial_rx_tx_control_test
